// ---- hdl/brake_seq_pkg.sv ----
// Purpose: shared constants and types for the external brake sequencer
// Assumes: 25 MHz hclk, 32-bit AHB-Lite register bus
// Notes: frequency in 0.01 Hz, current in 0.1 % of rated, waits in 10 ms ticks
package brake_seq_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // ****************************************************************
    // ranges and reset values
    // ****************************************************************
    localparam int WAIT_W = 9;
    localparam logic [8:0] WAIT_MAX = 9'h1f4;
    localparam logic [8:0] WAIT_RST = 9'h000;
    localparam int FREQ_W = 16;
    localparam logic [15:0] FREQ_MAX = 16'h9c40;
    localparam logic [15:0] FREQ_RST = 16'h0000;
    localparam logic [15:0] RAMP_STEP = 16'h0064;
    localparam int CUR_W = 11;
    localparam logic [10:0] CUR_MAX = 11'h7d0;
    localparam logic [10:0] CUR_RATED = 11'h3e8;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WAIT_REL = 8'h04;
    localparam logic [7:0] ADDR_WAIT_ACC = 8'h08;
    localparam logic [7:0] ADDR_WAIT_STOP = 8'h0c;
    localparam logic [7:0] ADDR_WAIT_CONF = 8'h10;
    localparam logic [7:0] ADDR_REL_FREQ = 8'h14;
    localparam logic [7:0] ADDR_BRK_FREQ = 8'h18;
    localparam logic [7:0] ADDR_REL_CUR = 8'h1c;
    localparam logic [7:0] ADDR_CMD_FREQ = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_OUT_FREQ = 8'h28;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h2c;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h30;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h34;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CONF_BIT = 1;
    localparam int IRQ_W = 4;
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_REL_ON = 1;
    localparam int IRQ_REL_OFF = 2;
    localparam int IRQ_STOPPED = 3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ACCEL_REL = 4'h1,
        ST_WAIT_REL = 4'h3,
        ST_CONF_ON = 4'h2,
        ST_WAIT_ACC = 4'h6,
        ST_RUN = 4'h7,
        ST_DECEL_BRK = 4'h5,
        ST_CONF_OFF = 4'h4,
        ST_WAIT_STOP = 4'hc,
        ST_DECEL_ZERO = 4'hd,
        ST_TRIP = 4'hf
    } seq_state_t;

    typedef struct packed {
        logic enable;
        logic conf_assigned;
        logic [8:0] wait_rel;
        logic [8:0] wait_acc;
        logic [8:0] wait_stop;
        logic [8:0] wait_conf;
        logic [15:0] rel_freq;
        logic [15:0] brk_freq;
        logic [10:0] rel_cur;
        logic [15:0] cmd_freq;
    } seq_cfg_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_req_t;

endpackage

// ---- hdl/tick_divider.sv ----
// Purpose: one-cycle enable pulse every CYCLES clocks
// Assumes: single clock domain
// Notes: sets the 10 ms timing grain for waits and ramping
`timescale 1ns/1ps
module tick_divider #(
    parameter int CYCLES = brake_seq_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic tick
);
    logic [31:0] cnt_q;
    logic tick_q;
    wire logic wrap = (cnt_q == 32'(CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
            tick_q <= wrap;
        end
    end

    assign tick = tick_q;
endmodule

// ---- hdl/freq_ramp.sv ----
// Purpose: linear output-frequency ramp toward a target
// Assumes: step_en is a one-cycle pulse
// Notes: force_zero cuts the output at once, as on a trip
`timescale 1ns/1ps
module freq_ramp #(
    parameter logic [15:0] STEP = brake_seq_pkg::RAMP_STEP
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic step_en,
    input wire logic force_zero,
    input wire logic [15:0] target,
    output logic [15:0] freq,
    output logic at_target
);
    logic [15:0] freq_q;
    wire logic [15:0] diff_up = target - freq_q;
    wire logic [15:0] diff_dn = freq_q - target;
    wire logic go_up = (target > freq_q);
    wire logic [15:0] up_d = (diff_up > STEP) ? freq_q + STEP : target;
    wire logic [15:0] dn_d = (diff_dn > STEP) ? freq_q - STEP : target;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_q <= brake_seq_pkg::FREQ_RST;
        end else if (force_zero) begin
            freq_q <= 16'h0000;
        end else if (step_en) begin
            freq_q <= go_up ? up_d : dn_d;
        end
    end

    assign freq = freq_q;
    assign at_target = (freq_q == target);
endmodule

// ---- hdl/brake_sequencer.sv ----
// Purpose: external mechanical brake sequencer with AHB-Lite registers
// Assumes: run_cmd, out_current and brake_confirm_input synchronous to hclk
// Notes: zero-wait bus slave; waits resolve to whole 10 ms ticks
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

// Operation
// [RULE_01] When enabled, a run command starts the output and ramps to the release frequency.
// [RULE_02] At the release frequency the release wait runs, then the brake release goes on.
// [RULE_03] Current below the release threshold withholds release and trips with brake error.
// [RULE_04] With confirmation assigned, frequency holds after release until confirm or trip.
// [RULE_05] Without confirmation the confirm wait is skipped and the acceleration wait follows.
// [RULE_06] After confirm or release the acceleration wait runs, then ramping to command.
// [RULE_07] Removing run decelerates to the braking frequency, then drops the brake release.
// [RULE_08] With confirmation assigned, frequency holds until confirm drops, else trip on timeout.
// [RULE_09] Without confirmation the stopping wait follows release removal directly.
// [RULE_10] After confirm drops or release drops, the stopping wait runs, then ramping to 0 Hz.
// [RULE_11] The four waits are settable 0 to 5 s in 10 ms steps, reset value zero.
// [RULE_12] Release and braking frequencies are settable 0 to 400 Hz, reset value zero.
// [RULE_13] The release current threshold is 0 to 200 % of rated, reset value rated current.
// [RULE_14] A disable or enable setting, reset disabled, gates the whole brake sequence; the code reads it only in ST_IDLE, not during a sequence.
// [RULE_15] The integrator routes the release and error outputs to output terminals.
// [RULE_16] The external brake drives confirm high when released and low when engaged.
// [RULE_17] Any trip drops the release and holds the error output until reset.
module brake_sequencer #(
    parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES,
    parameter logic [15:0] RAMP_STEP = brake_seq_pkg::RAMP_STEP
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic run_cmd,
    input wire logic [10:0] out_current,
    input wire logic brake_confirm_input,
    output logic brake_release_output,
    output logic brake_error_output,
    output logic [15:0] out_freq,
    output logic irq
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
        clamp16 = (v > mx) ? mx : v;
    endfunction

    function automatic logic [8:0] wait_val(input logic [31:0] v);
        wait_val = (v[31:9] != 23'h0) ? brake_seq_pkg::WAIT_MAX
                 : ((v[8:0] > brake_seq_pkg::WAIT_MAX) ? brake_seq_pkg::WAIT_MAX : v[8:0]);
    endfunction

    // ****************************************************************
    // bus slave
    // ****************************************************************
    brake_seq_pkg::ahb_req_t req_q;
    brake_seq_pkg::seq_cfg_t cfg_q;
    brake_seq_pkg::seq_state_t state_q;
    brake_seq_pkg::seq_state_t state_d;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic [3:0] irq_st_q;
    logic [3:0] irq_en_q;
    logic irq_q;
    logic rel_q;
    logic err_q;
    logic [8:0] wait_cnt_q;
    logic [15:0] freq_w;
    logic at_target_w;
    logic tick_w;

    wire logic take = hsel & hready & htrans[1];
    wire logic wr = req_q.valid & req_q.write;
    wire logic [7:0] ra = haddr[7:0];
    wire logic [31:0] wd = hwdata;
    wire logic wr_ctrl = wr & (req_q.addr == brake_seq_pkg::ADDR_CTRL);
    wire logic wr_wrel = wr & (req_q.addr == brake_seq_pkg::ADDR_WAIT_REL);
    wire logic wr_wacc = wr & (req_q.addr == brake_seq_pkg::ADDR_WAIT_ACC);
    wire logic wr_wstop = wr & (req_q.addr == brake_seq_pkg::ADDR_WAIT_STOP);
    wire logic wr_wconf = wr & (req_q.addr == brake_seq_pkg::ADDR_WAIT_CONF);
    wire logic wr_rfreq = wr & (req_q.addr == brake_seq_pkg::ADDR_REL_FREQ);
    wire logic wr_bfreq = wr & (req_q.addr == brake_seq_pkg::ADDR_BRK_FREQ);
    wire logic wr_rcur = wr & (req_q.addr == brake_seq_pkg::ADDR_REL_CUR);
    wire logic wr_cmd = wr & (req_q.addr == brake_seq_pkg::ADDR_CMD_FREQ);
    wire logic wr_ien = wr & (req_q.addr == brake_seq_pkg::ADDR_IRQ_EN);
    wire logic wr_iclr = wr & (req_q.addr == brake_seq_pkg::ADDR_IRQ_CLR);
    wire logic [15:0] wd_freq = (wd[31:16] != 16'h0) ? brake_seq_pkg::FREQ_MAX
                                : clamp16(wd[15:0], brake_seq_pkg::FREQ_MAX);
    wire logic [15:0] wd_cur16 = (wd[31:11] != 21'h0) ? {5'h00, brake_seq_pkg::CUR_MAX}
                                 : clamp16({5'h00, wd[10:0]}, {5'h00, brake_seq_pkg::CUR_MAX});

    wire logic [31:0] status_word = {22'h000000, brake_confirm_input, run_cmd,
                                     err_q, rel_q, 2'b00, state_q};
    wire logic [31:0] rd_mux =
        (ra == brake_seq_pkg::ADDR_CTRL) ? {30'h0, cfg_q.conf_assigned, cfg_q.enable} :
        (ra == brake_seq_pkg::ADDR_WAIT_REL) ? {23'h0, cfg_q.wait_rel} :
        (ra == brake_seq_pkg::ADDR_WAIT_ACC) ? {23'h0, cfg_q.wait_acc} :
        (ra == brake_seq_pkg::ADDR_WAIT_STOP) ? {23'h0, cfg_q.wait_stop} :
        (ra == brake_seq_pkg::ADDR_WAIT_CONF) ? {23'h0, cfg_q.wait_conf} :
        (ra == brake_seq_pkg::ADDR_REL_FREQ) ? {16'h0, cfg_q.rel_freq} :
        (ra == brake_seq_pkg::ADDR_BRK_FREQ) ? {16'h0, cfg_q.brk_freq} :
        (ra == brake_seq_pkg::ADDR_REL_CUR) ? {21'h0, cfg_q.rel_cur} :
        (ra == brake_seq_pkg::ADDR_CMD_FREQ) ? {16'h0, cfg_q.cmd_freq} :
        (ra == brake_seq_pkg::ADDR_STATUS) ? status_word :
        (ra == brake_seq_pkg::ADDR_OUT_FREQ) ? {16'h0, freq_w} :
        (ra == brake_seq_pkg::ADDR_IRQ_STAT) ? {28'h0, irq_st_q} :
        (ra == brake_seq_pkg::ADDR_IRQ_EN) ? {28'h0, irq_en_q} : 32'h0000_0000;

    // read data registered at the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
            hrdata_q <= 32'h0000_0000;
            hreadyout_q <= 1'b0;
        end else begin
            req_q <= '{valid: take, write: hwrite, addr: haddr[7:0]};
            hrdata_q <= (take && !hwrite && haddr[31:8] == 24'h0) ? rd_mux : 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q.enable <= 1'b0;
            cfg_q.conf_assigned <= 1'b0;
            cfg_q.wait_rel <= brake_seq_pkg::WAIT_RST;
            cfg_q.wait_acc <= brake_seq_pkg::WAIT_RST;
            cfg_q.wait_stop <= brake_seq_pkg::WAIT_RST;
            cfg_q.wait_conf <= brake_seq_pkg::WAIT_RST;
            cfg_q.rel_freq <= brake_seq_pkg::FREQ_RST;
            cfg_q.brk_freq <= brake_seq_pkg::FREQ_RST;
            cfg_q.rel_cur <= brake_seq_pkg::CUR_RATED;
            cfg_q.cmd_freq <= brake_seq_pkg::FREQ_RST;
            irq_en_q <= 4'h0;
        end else begin
            // [RULE_14] enable setting
            if (wr_ctrl) begin
                cfg_q.enable <= wd[brake_seq_pkg::CTRL_EN_BIT];
                cfg_q.conf_assigned <= wd[brake_seq_pkg::CTRL_CONF_BIT];
            end
            // [RULE_11] saturating wait limits
            if (wr_wrel) cfg_q.wait_rel <= wait_val(wd);
            if (wr_wacc) cfg_q.wait_acc <= wait_val(wd);
            if (wr_wstop) cfg_q.wait_stop <= wait_val(wd);
            if (wr_wconf) cfg_q.wait_conf <= wait_val(wd);
            // [RULE_12] frequency limits
            if (wr_rfreq) cfg_q.rel_freq <= wd_freq;
            if (wr_bfreq) cfg_q.brk_freq <= wd_freq;
            if (wr_cmd) cfg_q.cmd_freq <= wd_freq;
            // [RULE_13] current threshold limit
            if (wr_rcur) cfg_q.rel_cur <= wd_cur16[10:0];
            if (wr_ien) irq_en_q <= wd[3:0];
        end
    end

    // ****************************************************************
    // timing and ramp
    // ****************************************************************
    tick_divider #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick_w)
    );

    logic [15:0] target_w;
    wire logic in_trip = (state_q == brake_seq_pkg::ST_TRIP);

    freq_ramp #(
        .STEP(RAMP_STEP)
    ) u_ramp (
        .hclk(hclk),
        .hresetn(hresetn),
        .step_en(tick_w),
        .force_zero(in_trip),
        .target(target_w),
        .freq(freq_w),
        .at_target(at_target_w)
    );

    // ****************************************************************
    // sequencer
    // ****************************************************************
    wire logic conf = brake_confirm_input;
    wire logic conf_en = cfg_q.conf_assigned;
    // equal current passes; only a shortfall trips
    wire logic cur_low = (out_current < cfg_q.rel_cur);
    wire logic [8:0] wait_lim =
        (state_q == brake_seq_pkg::ST_WAIT_REL) ? cfg_q.wait_rel :
        (state_q == brake_seq_pkg::ST_WAIT_ACC) ? cfg_q.wait_acc :
        (state_q == brake_seq_pkg::ST_WAIT_STOP) ? cfg_q.wait_stop : cfg_q.wait_conf;
    wire logic wait_done = (wait_cnt_q >= wait_lim);
    wire logic [15:0] bypass_freq = run_cmd ? cfg_q.cmd_freq : 16'h0000;

    // disabled in ST_IDLE: the ramp follows run directly and the brake outputs stay low
    assign target_w =
        (state_q == brake_seq_pkg::ST_IDLE) ? (cfg_q.enable ? 16'h0000 : bypass_freq) :
        (state_q == brake_seq_pkg::ST_RUN) ? cfg_q.cmd_freq :
        (state_q == brake_seq_pkg::ST_DECEL_BRK ||
         state_q == brake_seq_pkg::ST_CONF_OFF ||
         state_q == brake_seq_pkg::ST_WAIT_STOP) ? cfg_q.brk_freq :
        (state_q == brake_seq_pkg::ST_DECEL_ZERO || in_trip) ? 16'h0000 : cfg_q.rel_freq;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            brake_seq_pkg::ST_IDLE: begin
                // [RULE_01] start ramp to release freq
                if (cfg_q.enable && run_cmd && freq_w == 16'h0000)
                    state_d = brake_seq_pkg::ST_ACCEL_REL;
            end

            brake_seq_pkg::ST_ACCEL_REL: begin
                if (!run_cmd) state_d = brake_seq_pkg::ST_DECEL_ZERO;
                else if (at_target_w) state_d = brake_seq_pkg::ST_WAIT_REL;
            end

            brake_seq_pkg::ST_WAIT_REL: begin
                // [RULE_02] release after wait
                // [RULE_03] low current trips
                // [RULE_05] skip confirm wait
                if (!run_cmd) state_d = brake_seq_pkg::ST_DECEL_ZERO;
                else if (wait_done && cur_low) state_d = brake_seq_pkg::ST_TRIP;
                else if (wait_done && conf_en) state_d = brake_seq_pkg::ST_CONF_ON;
                else if (wait_done) state_d = brake_seq_pkg::ST_WAIT_ACC;
            end

            brake_seq_pkg::ST_CONF_ON: begin
                // [RULE_04] hold until confirm
                if (conf) state_d = brake_seq_pkg::ST_WAIT_ACC;
                else if (wait_done) state_d = brake_seq_pkg::ST_TRIP;
            end

            brake_seq_pkg::ST_WAIT_ACC: begin
                // [RULE_06] accel wait then run
                if (!run_cmd) state_d = brake_seq_pkg::ST_DECEL_BRK;
                else if (wait_done) state_d = brake_seq_pkg::ST_RUN;
            end

            brake_seq_pkg::ST_RUN: begin
                // [RULE_07] stop toward braking freq
                if (!run_cmd) state_d = brake_seq_pkg::ST_DECEL_BRK;
            end

            brake_seq_pkg::ST_DECEL_BRK: begin
                // [RULE_09] skip confirm when unassigned
                if (at_target_w && conf_en) state_d = brake_seq_pkg::ST_CONF_OFF;
                else if (at_target_w) state_d = brake_seq_pkg::ST_WAIT_STOP;
            end

            brake_seq_pkg::ST_CONF_OFF: begin
                // [RULE_08] hold until confirm drops
                if (!conf) state_d = brake_seq_pkg::ST_WAIT_STOP;
                else if (wait_done) state_d = brake_seq_pkg::ST_TRIP;
            end

            brake_seq_pkg::ST_WAIT_STOP: begin
                // [RULE_10] stop wait then to zero
                if (wait_done) state_d = brake_seq_pkg::ST_DECEL_ZERO;
            end

            brake_seq_pkg::ST_DECEL_ZERO: begin
                if (freq_w == 16'h0000) state_d = brake_seq_pkg::ST_IDLE;
            end

            brake_seq_pkg::ST_TRIP: begin
                // [RULE_17] trip held until reset
                state_d = brake_seq_pkg::ST_TRIP;
            end
            default: state_d = brake_seq_pkg::ST_TRIP;
        endcase
    end

    wire logic rel_d = (state_d == brake_seq_pkg::ST_CONF_ON) ||
                       (state_d == brake_seq_pkg::ST_WAIT_ACC) ||
                       (state_d == brake_seq_pkg::ST_RUN) ||
                       (state_d == brake_seq_pkg::ST_DECEL_BRK);
    wire logic err_d = (state_d == brake_seq_pkg::ST_TRIP);
    wire logic new_state = (state_d != state_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= brake_seq_pkg::ST_IDLE;
            wait_cnt_q <= 9'h000;
            rel_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // wait counts whole ticks from state entry, saturating
            if (new_state) wait_cnt_q <= 9'h000;
            else if (tick_w && !wait_done) wait_cnt_q <= wait_cnt_q + 9'h001;
            // [RULE_17] release dropped on trip
            rel_q <= rel_d & ~err_d;
            err_q <= err_d;
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    wire logic [3:0] irq_ev = {
        (state_q == brake_seq_pkg::ST_DECEL_ZERO) && (state_d == brake_seq_pkg::ST_IDLE),
        rel_q & ~rel_d,
        ~rel_q & rel_d & ~err_d,
        ~err_q & err_d
    };
    wire logic [3:0] irq_clr = wr_iclr ? wd[3:0] : 4'h0;

    // an event in the clearing cycle survives the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
            irq_q <= |(((irq_st_q & ~irq_clr) | irq_ev) & irq_en_q);
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign brake_release_output = rel_q;
    assign brake_error_output = err_q;
    assign out_freq = freq_w;
    assign irq = irq_q;

endmodule

// ---- dv/brake_seq_chk.sv ----
// Purpose: output checks for the brake sequencer
// Assumes: one hclk domain, async low reset
// Notes: bound to every sequencer instance
`timescale 1ns/1ps
module brake_seq_chk #(
    parameter int TICK_CYCLES = 4,
    parameter logic [15:0] RAMP_STEP = 16'h0100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run_cmd,
    input wire logic brake_release_output,
    input wire logic brake_error_output,
    input wire logic [15:0] out_freq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_trip; $rose(brake_error_output); endsequence
    sequence s_on; $rose(brake_release_output); endsequence
    sequence s_off; $fell(brake_release_output) ##0 !brake_error_output; endsequence
    a_err_held: assert property (brake_error_output |=> brake_error_output)
        else $error("error dropped");
    a_err_no_rel: assert property (brake_error_output |-> !brake_release_output)
        else $error("release during trip");
    a_trip_cuts_freq: assert property (s_trip |-> ##[0:1] out_freq == 16'h0)
        else $error("freq kept on trip");
    a_rel_needs_run: assert property (s_on |-> $past(run_cmd))
        else $error("release without run");
    a_rel_on_hold: assert property (s_on |-> $stable(out_freq))
        else $error("freq moved at release");
    a_rel_off_stop: assert property (s_off |-> !$past(run_cmd))
        else $error("release dropped in run");
    a_rel_off_hold: assert property (s_off |=> $stable(out_freq))
        else $error("freq moved at drop");
    a_stop_to_zero: assert property (s_off |-> ##[1:1000] out_freq == 16'h0)
        else $error("no stop after drop");
endmodule
bind brake_sequencer brake_seq_chk #(.TICK_CYCLES(TICK_CYCLES), .RAMP_STEP(RAMP_STEP)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .run_cmd(run_cmd),
    .brake_release_output(brake_release_output), .brake_error_output(brake_error_output),
    .out_freq(out_freq));

// ---- dv/brake_model.sv ----
// Purpose: external brake with a release contact
// Assumes: mode 1 never confirms, mode 2 sticks once confirmed
// Notes: slow stretches the contact delay near the confirm limit
`timescale 1ns/1ps
module brake_model (
    input wire logic hclk,
    input wire logic release_in,
    input wire logic [1:0] mode,
    input wire logic slow,
    output logic confirm
);
    logic want;
    int cnt = 0;
    initial confirm = 1'b0;
    assign want = (mode == 2'h1) ? 1'b0 : ((mode == 2'h2 && confirm) ? 1'b1 : release_in);
    always @(posedge hclk) begin
        cnt <= (want == confirm) ? 0 : cnt + 1;
        if (want != confirm && cnt >= (slow ? 8 : 2))
            confirm <= want;
    end
endmodule

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the brake sequencer
// Assumes: 4-clock tick and large ramp step keep runs short
// Notes: rows check reset values and limits, sequences follow
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
`define WT(c) for (int k = 0; !(c); k++) begin if (k > 3000) begin mismatches++; \
    final_report(); end @(posedge hclk); end
module testbench;
    typedef struct {logic [7:0] a; logic [15:0] b; logic [15:0] w; logic [15:0] e;} row_t;
    logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, run_cmd = '0, slow = '0;
    logic seen_rel = '0;
    logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
    logic [1:0] htrans = '0, mode = '0;
    logic [10:0] out_current = 11'h3e8;
    logic [15:0] out_freq;
    logic hready, hresp, confirm, rel, err, irq;
    int mismatches = 0, checks_done = 0;
    row_t rows[16] = '{'{8'h04, 16'h0, 16'h1ff, 16'h1f4}, '{8'h04, 16'h1f4, 16'h2, 16'h2},
        '{8'h08, 16'h0, 16'h1, 16'h1}, '{8'h0c, 16'h0, 16'h1, 16'h1},
        '{8'h10, 16'h0, 16'h3, 16'h3}, '{8'h14, 16'h0, 16'hffff, 16'h9c40},
        '{8'h14, 16'h9c40, 16'h200, 16'h200}, '{8'h18, 16'h0, 16'h100, 16'h100},
        '{8'h1c, 16'h3e8, 16'h7ff, 16'h7d0}, '{8'h1c, 16'h7d0, 16'h3e8, 16'h3e8},
        '{8'h20, 16'h0, 16'h400, 16'h400}, '{8'h30, 16'h0, 16'hf, 16'hf},
        '{8'h00, 16'h0, 16'h0, 16'h0}, '{8'h24, 16'h0, 16'hffff, 16'h0},
        '{8'h3c, 16'h0, 16'hff, 16'h0}, '{8'h34, 16'h0, 16'hf, 16'h0}};
    always #20 hclk = ~hclk;
    brake_sequencer #(.TICK_CYCLES(4), .RAMP_STEP(16'h0100)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .run_cmd(run_cmd), .out_current(out_current),
        .brake_confirm_input(confirm), .brake_release_output(rel), .brake_error_output(err),
        .out_freq(out_freq), .irq(irq));
    brake_model u_brake (.hclk(hclk), .release_in(rel), .mode(mode), .slow(slow),
        .confirm(confirm));
    always @(posedge rel) begin
        #1 `CHK("freq at release", 16'h0200, out_freq)
        seen_rel = 1'b1;
    end
    always @(negedge rel) #1 if (!err && hresetn) `CHK("freq at drop", 16'h0100, out_freq)
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rdy;
        `WT(hready === 1'b1 && $time > 0)
        @(posedge hclk);
        `WT(hready === 1'b1)
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask
    task automatic setup;
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        foreach (rows[i]) begin
            bus(1'b0, rows[i].a, 32'h0);
            `CHK("before", {16'h0, rows[i].b}, rd)
            bus(1'b1, rows[i].a, {16'h0, rows[i].w});
            bus(1'b0, rows[i].a, 32'h0);
            `CHK("after", {16'h0, rows[i].e}, rd)
            `CHK("okay", 1'b0, hresp)
        end
        $display("register rows done");
    endtask
    task automatic cycle(input logic [1:0] c, input logic [1:0] m, input logic [10:0] cur,
        input logic s, input logic e, input logic r);
        bus(1'b1, 8'h00, {30'h0, c});
        mode <= m;
        slow <= s;
        out_current <= cur;
        run_cmd <= 1'b1;
        seen_rel = 1'b0;
        `WT(out_freq === 16'h0400 || err === 1'b1)
        run_cmd <= 1'b0;
        `WT(out_freq === 16'h0 && rel === 1'b0)
        bus(1'b0, 8'h24, 32'h0);
        `CHK("state", e ? 4'hf : 4'h0, rd[3:0])
        `CHK("error", e, err)
        `CHK("release seen", r, seen_rel)
        $display("sequence done ctrl %0h mode %0h", c, m);
    endtask
    initial begin
        setup();
        cycle(2'h1, 2'h0, 11'h3e8, 1'b0, 1'b0, 1'b1);
        bus(1'b0, 8'h2c, 32'h0);
        `CHK("irq status", 32'he, rd)
        `CHK("irq line", 1'b1, irq)
        bus(1'b1, 8'h30, 32'h0);
        bus(1'b0, 8'h28, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, 8'h34, 32'hf);
        bus(1'b1, 8'h30, 32'hf);
        bus(1'b0, 8'h2c, 32'h0);
        `CHK("irq cleared", 32'h0, rd)
        `CHK("irq idle", 1'b0, irq)
        cycle(2'h3, 2'h0, 11'h3e8, 1'b1, 1'b0, 1'b1);
        cycle(2'h0, 2'h0, 11'h3e8, 1'b0, 1'b0, 1'b0);
        setup();
        cycle(2'h1, 2'h0, 11'h3e7, 1'b0, 1'b1, 1'b0);
        setup();
        cycle(2'h3, 2'h1, 11'h3e8, 1'b0, 1'b1, 1'b1);
        setup();
        cycle(2'h3, 2'h2, 11'h3e8, 1'b0, 1'b1, 1'b1);
        final_report();
    end
endmodule
